// file: fbrp_read_port.sv
// Behaviour
// - async read: address latched on strobe rise
// - reset leaves device in async array read
// - banks stay readable until command write
// - after configuration set with sync_en, only burst reads
// - first word after latency, then one per edge
// - two-edge gap, flag low, at 64-word crossing
// - standard part: 3Eh/3Fh start skips crossing gap
// - reduced part: 3Eh/3Fh start adds initial gap
// - continuous burst wraps; stops on ce, clear, strobe
// - idle bank crossing adds the two-edge gap
// - busy bank crossing returns status, ignores clock
// - slow clock adds latency, flag held low
// - wrap modes cycle within aligned group
// - wrap modes never add boundary gaps
// - output enable high suspends, state kept
// - output enable low resumes at next edge
// - valid flag driven whenever chip enabled
// - reduced part: flag rise marks first word
// - standard part: odd start delays one edge
// - configuration register holds burst parameters
// - rising clock edge active by default
// - flag high when data valid, else low

`include "fbrp_regs.svh"

module fbrp_read_port #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter logic [5:0] SLOW_EXTRA = 6'h02
) (
  input wire logic core_clk,                    // core clock, 10 MHz
  input wire logic rst_n,                       // async reset
  input wire logic hardware_clear_n,            // hardware reset pin
  input wire logic chip_enable_n,               // chip enable
  input wire logic output_enable_n,             // output enable
  input wire logic write_enable_n,              // write enable
  input wire logic address_valid_n,             // address strobe
  input wire logic burst_clk,                   // sampled burst clock
  input wire logic [ADDR_W-1:0] address_inputs, // word address
  input wire logic reduced_wait_part,           // reduced-wait option
  input wire logic slow_clock,                  // burst clock below 6 MHz
  input wire logic cfg_load,                    // config set, pulse
  input wire fbrp_pkg::fbrp_cfg_s cfg_in,       // new config value
  input wire logic cmd_write,                   // command write, pulse
  input wire logic [3:0] cmd_bank_sel,          // banks the command alters
  input wire logic [3:0] bank_busy,             // program or erase per bank
  input wire logic [DATA_W-1:0] status_word,    // status read value
  input wire logic [DATA_W-1:0] array_rdata,    // array word at array_addr
  output logic [ADDR_W-1:0] array_addr,         // array word address
  output logic [DATA_W-1:0] data_lines_out,     // data pins value
  output logic data_lines_oe,                   // data pins enable
  output logic data_valid_flag,                 // ready pin value
  output logic data_valid_flag_oe,              // ready pin enable
  output logic [3:0] bank_read_en,              // banks open for reads
  output fbrp_pkg::fbrp_cfg_s cfg_state,        // current configuration
  output logic sync_mode                        // burst reads active
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // bank bases and 64-word blocks need the full 22-bit word address
  if (ADDR_W != 22) begin : g_bad_addr
    $error("fbrp_read_port needs ADDR_W of 22");
  end
  if (DATA_W < 1) begin : g_bad_data
    $error("fbrp_read_port needs DATA_W of at least 1");
  end
  // the six-bit wait counter must hold the longest initial wait
  if (SLOW_EXTRA > 6'h2D) begin : g_bad_slow
    $error("fbrp_read_port needs SLOW_EXTRA of at most 2Dh");
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  fbrp_pkg::fbrp_state_e state;
  fbrp_pkg::fbrp_cfg_s cfg;
  logic [ADDR_W-1:0] addr;
  logic [5:0] cnt;
  logic skip_gap;
  logic flag;
  logic [DATA_W-1:0] data_q;

  // pin samples from the last core edge, and the bank read enables
  logic clk_prev;
  logic avd_prev;
  logic [3:0] bank_en;

  // ==========================================================================
  // decode
  // ==========================================================================
  // burst clock edge detect; polarity chosen by the configuration
  wire logic clk_rise = burst_clk & ~clk_prev;
  wire logic clk_fall = ~burst_clk & clk_prev;
  wire logic act_edge = cfg.falling_edge ? clk_fall : clk_rise;
  wire logic avd_rise = address_valid_n & ~avd_prev;

  // bus qualifiers; a suspended burst ignores its clock
  wire logic read_sel = ~chip_enable_n & write_enable_n;
  wire logic suspended = output_enable_n;
  wire logic step = act_edge & ~suspended;
  wire logic new_addr = read_sel & ~address_valid_n & act_edge;

  // continuous bursts cross blocks and banks
  wire logic is_cont = (cfg.mode == fbrp_pkg::FBRP_CONT);

  // start position inside the 64-word block
  wire logic [5:0] start_lo = address_inputs[`FBRP_BLOCK_MSB:0];
  wire logic start_late = (start_lo == `FBRP_BLOCK_PRELAST) |
                          (start_lo == `FBRP_BLOCK_LAST);

  // initial latency: waits, plus part-specific and slow-clock extras
  wire logic [5:0] rw_extra = (reduced_wait_part & start_late) ?
                              `FBRP_RW_START_EDGES : 6'h00;
  wire logic [5:0] odd_extra = (~reduced_wait_part & address_inputs[0]) ?
                               `FBRP_ODD_START_EDGES : 6'h00;
  wire logic [5:0] slow_extra = slow_clock ? SLOW_EXTRA : 6'h00;
  wire logic [5:0] init_lat = {2'h0, cfg.wait_states} + rw_extra +
                              odd_extra + slow_extra;

  // wrap group mask from the burst mode
  logic [5:0] wrap_mask;
  always_comb begin
    case (cfg.mode)
      fbrp_pkg::FBRP_WRAP8: wrap_mask = `FBRP_WRAP8_MASK;
      fbrp_pkg::FBRP_WRAP16: wrap_mask = `FBRP_WRAP16_MASK;
      fbrp_pkg::FBRP_WRAP32: wrap_mask = `FBRP_WRAP32_MASK;
      default: wrap_mask = 6'h00;
    endcase
  end

  // next burst address: full increment, or increment within the group
  wire logic [ADDR_W-1:0] addr_inc = addr + 22'h000001;
  wire logic [5:0] lo_inc = addr[5:0] + 6'h01;
  wire logic [ADDR_W-1:0] addr_wrap = {addr[ADDR_W-1:6],
                                       (addr[5:0] & ~wrap_mask) |
                                       (lo_inc & wrap_mask)};
  wire logic [ADDR_W-1:0] next_addr = is_cont ? addr_inc : addr_wrap;

  // bank of an address; banks A and D are smaller than banks B and C
  function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a);
    logic [1:0] b;
    b = 2'h0;
    // search from the top bank down
    if (a >= `FBRP_BANK_D_BASE) begin
      b = 2'h3;
    end else if (a >= `FBRP_BANK_C_BASE) begin
      b = 2'h2;
    end else if (a >= `FBRP_BANK_B_BASE) begin
      b = 2'h1;
    end
    return b;
  endfunction

  // bank of this word and of the next one
  wire logic [1:0] cur_bank = bank_of(addr);
  wire logic [1:0] nxt_bank = bank_of(next_addr);
  // wrap modes never reach a 64-word crossing
  wire logic crossing = is_cont & (addr[5:0] == `FBRP_BLOCK_LAST);
  wire logic bank_change = crossing & (cur_bank != nxt_bank);

  // a closed bank answers like a busy one: status only
  wire logic nxt_busy = bank_busy[nxt_bank] | ~bank_en[nxt_bank];
  wire logic cur_busy = bank_busy[cur_bank] | ~bank_en[cur_bank];

  // flag rises one edge early when so configured and the wait is about over
  wire logic early_hit = cfg.flag_early & (cnt == 6'h02);

  // ==========================================================================
  // pin outputs
  // ==========================================================================
  // data pins only while selected for reading with outputs enabled
  assign data_lines_oe = read_sel & ~output_enable_n & hardware_clear_n;
  assign data_lines_out = data_q;
  // the ready pin follows chip enable alone, even while suspended
  assign data_valid_flag_oe = ~chip_enable_n;
  assign data_valid_flag = flag;

  // state seen from outside
  assign array_addr = addr;
  assign bank_read_en = bank_en;
  assign cfg_state = cfg;
  assign sync_mode = cfg.sync_en;

  // ==========================================================================
  // pin history for edge detection
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'b0;
      avd_prev <= 1'b1;
    end else begin
      clk_prev <= burst_clk;
      avd_prev <= address_valid_n;
    end
  end

  // ==========================================================================
  // configuration and bank read enables
  // ==========================================================================
  // a hardware clear drops back to async reads; config set with sync_en enables bursts
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= '{wait_states: `FBRP_WAIT_RST, mode: fbrp_pkg::FBRP_CONT,
               falling_edge: 1'b0, flag_early: 1'b0, sync_en: 1'b0};
    end else if (!hardware_clear_n) begin
      cfg.sync_en <= 1'b0;
    end else if (cfg_load) begin
      cfg <= cfg_in;
    end
  end

  // banks stay readable until a command write alters them
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_en <= `FBRP_BANK_EN_RST;
    end else if (!hardware_clear_n) begin
      bank_en <= `FBRP_BANK_EN_RST;
    end else if (cmd_write) begin
      bank_en <= bank_en & ~cmd_bank_sel;
    end
  end

  // ==========================================================================
  // read data register
  // ==========================================================================
  // status replaces array data in the status state or a closed bank
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= '0;
    end else if (state == fbrp_pkg::FBRP_STATUS || cur_busy) begin
      data_q <= status_word;
    end else if (!(suspended && state != fbrp_pkg::FBRP_ASYNC)) begin
      data_q <= array_rdata;
    end
  end

  // ==========================================================================
  // read engine
  // ==========================================================================
  // one process keeps address, counter, gap skip and flag in step
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= fbrp_pkg::FBRP_ASYNC;
      addr <= '0;
      cnt <= 6'h00;
      skip_gap <= 1'b0;
      flag <= 1'b0;
    end else if (!hardware_clear_n) begin
      state <= fbrp_pkg::FBRP_ASYNC;
      flag <= 1'b0;
      skip_gap <= 1'b0;
    end else if (cfg_load) begin
      // a configuration set drops any burst in flight
      state <= cfg_in.sync_en ? fbrp_pkg::FBRP_SYNC_IDLE : fbrp_pkg::FBRP_ASYNC;
      flag <= 1'b0;
    end else if (!cfg.sync_en) begin
      // async reads: address taken when the strobe rises
      state <= fbrp_pkg::FBRP_ASYNC;
      flag <= 1'b0;
      if (avd_rise && read_sel) begin
        addr <= address_inputs;
      end
    end else if (chip_enable_n) begin
      // deselect ends the burst before the next word
      state <= fbrp_pkg::FBRP_SYNC_IDLE;
      flag <= 1'b0;
    end else if (new_addr) begin
      // a fresh address ends any burst and starts the initial wait
      addr <= address_inputs;
      cnt <= init_lat;
      skip_gap <= start_late;
      flag <= 1'b0;
      state <= fbrp_pkg::FBRP_LATENCY;
    end else begin
      case (state)
        fbrp_pkg::FBRP_SYNC_IDLE: begin
          flag <= 1'b0;
        end

        fbrp_pkg::FBRP_LATENCY: begin
          if (step) begin
            if (cnt <= 6'h01) begin
              state <= fbrp_pkg::FBRP_OUTPUT;
              flag <= 1'b1;
            end else begin
              cnt <= cnt - 6'h01;
              flag <= early_hit;
            end
          end
        end

        // one word per active edge
        fbrp_pkg::FBRP_OUTPUT: begin
          if (step) begin
            addr <= next_addr;
            // a busy bank ahead wins over the gap
            if (bank_change && nxt_busy) begin
              state <= fbrp_pkg::FBRP_STATUS;
              flag <= 1'b1;
            end else if (crossing && (bank_change || !skip_gap)) begin
              state <= fbrp_pkg::FBRP_BOUND;
              cnt <= `FBRP_BOUNDARY_EDGES + slow_extra;
              flag <= 1'b0;
              skip_gap <= 1'b0;
            end else begin
              flag <= 1'b1;
              if (crossing) begin
                skip_gap <= 1'b0;
              end
            end
          end
        end

        // gap edges at a boundary
        fbrp_pkg::FBRP_BOUND: begin
          if (step) begin
            if (cnt <= 6'h01) begin
              state <= fbrp_pkg::FBRP_OUTPUT;
              flag <= 1'b1;
            end else begin
              cnt <= cnt - 6'h01;
              flag <= early_hit;
            end
          end
        end

        fbrp_pkg::FBRP_STATUS: begin
          // clock ignored until a new address arrives
          flag <= 1'b1;
        end

        default: begin
          state <= fbrp_pkg::FBRP_SYNC_IDLE;
          flag <= 1'b0;
        end
      endcase
    end
  end

endmodule // fbrp_read_port

// file: fbrp_regs.svh
`ifndef FBRP_REGS_SVH
`define FBRP_REGS_SVH

// ==========================================================================
// timing
// ==========================================================================
// core clock period in ns (10 MHz)
`define FBRP_CLK_PERIOD_NS 100
// extra burst clock edges inserted at a 64-word or bank boundary
`define FBRP_BOUNDARY_EDGES 6'h02
// extra edges before the first word on a 3Eh/3Fh start, reduced-wait parts
`define FBRP_RW_START_EDGES 6'h02
// extra edge before the first word on an odd start, standard parts
`define FBRP_ODD_START_EDGES 6'h01

// ==========================================================================
// address layout
// ==========================================================================
// low address bits that count words inside a 64-word block
`define FBRP_BLOCK_MSB 5
`define FBRP_BLOCK_LAST 6'h3F
`define FBRP_BLOCK_PRELAST 6'h3E
// wrap group masks for the three linear wrap lengths
`define FBRP_WRAP8_MASK 6'h07
`define FBRP_WRAP16_MASK 6'h0F
`define FBRP_WRAP32_MASK 6'h1F
// first word of banks B, C and D; bank A starts at zero
`define FBRP_BANK_B_BASE 22'h080000
`define FBRP_BANK_C_BASE 22'h200000
`define FBRP_BANK_D_BASE 22'h380000

// ==========================================================================
// reset values
// ==========================================================================
`define FBRP_BANK_EN_RST 4'hF
`define FBRP_WAIT_RST 4'h5

`endif

// file: fbrp_pkg.sv
package fbrp_pkg;

  // burst read mode held in the configuration register
  typedef enum logic [1:0] {
    FBRP_CONT = 2'h0,
    FBRP_WRAP8 = 2'h1,
    FBRP_WRAP16 = 2'h2,
    FBRP_WRAP32 = 2'h3
  } fbrp_mode_e;

  // configuration register contents
  typedef struct packed {
    logic [3:0] wait_states;  // initial wait-state count
    fbrp_mode_e mode;         // burst read mode
    logic falling_edge;       // 1: falling clock edge is active
    logic flag_early;         // 1: valid flag rises one edge before data
    logic sync_en;            // 1: synchronous burst reads
  } fbrp_cfg_s;

  // read engine states, one-hot
  typedef enum logic [5:0] {
    FBRP_ASYNC = 6'h01,
    FBRP_SYNC_IDLE = 6'h02,
    FBRP_LATENCY = 6'h04,
    FBRP_OUTPUT = 6'h08,
    FBRP_BOUND = 6'h10,
    FBRP_STATUS = 6'h20
  } fbrp_state_e;

endpackage

// file: fbrp_read_port_sva.sv
// ==========================================================================
// port checker
// ==========================================================================
module fbrp_read_port_sva #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16,
  parameter logic [5:0] SLOW_EXTRA = 6'h02
) (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset
  input wire logic hardware_clear_n, // hardware clear
  input wire logic chip_enable_n, // chip enable
  input wire logic output_enable_n, // output enable
  input wire logic write_enable_n, // write enable
  input wire logic address_valid_n, // address strobe
  input wire logic [ADDR_W-1:0] address_inputs, // word address
  input wire logic cfg_load, // config set pulse
  input wire fbrp_pkg::fbrp_cfg_s cfg_in, // new config
  input wire logic cmd_write, // command write pulse
  input wire logic [3:0] cmd_bank_sel, // banks altered
  input wire logic [DATA_W-1:0] array_rdata, // array word
  input wire logic [ADDR_W-1:0] array_addr, // array address
  input wire logic [DATA_W-1:0] data_lines_out, // data pins
  input wire logic data_lines_oe, // data enable
  input wire logic data_valid_flag, // ready flag
  input wire logic data_valid_flag_oe, // ready enable
  input wire logic [3:0] bank_read_en, // open banks
  input wire fbrp_pkg::fbrp_cfg_s cfg_state, // config
  input wire logic sync_mode // burst mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic avd_q;
  logic take;
  logic [ADDR_W-1:0] taken_addr;
  // strobe rise seen here so the async check does not depend on pipeline depth
  assign take = address_valid_n && !avd_q && !chip_enable_n && write_enable_n && !sync_mode
    && hardware_clear_n;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avd_q <= 1'b1;
      taken_addr <= '0;
    end else begin
      avd_q <= address_valid_n;
      if (take) taken_addr <= address_inputs;
    end
  end
  a_flag_drive: assert property (
    data_valid_flag_oe == !chip_enable_n) else $error("flag enable wrong");
  a_data_drive: assert property (
    data_lines_oe == (!chip_enable_n && write_enable_n && !output_enable_n && hardware_clear_n))
    else $error("data enable wrong");
  a_async_addr: assert property (
    take |-> ##[1:2] array_addr == taken_addr) else $error("async address not latched");
  a_async_data: assert property (
    take && bank_read_en == 4'hF |-> ##[2:4] data_lines_out == $past(array_rdata))
    else $error("async data missing");
  a_clear_state: assert property (
    !hardware_clear_n |=> bank_read_en == 4'hF && !sync_mode) else $error("clear state wrong");
  a_cmd_close: assert property (
    cmd_write && hardware_clear_n |-> ##[1:2] (bank_read_en & cmd_bank_sel) == 4'h0)
    else $error("bank not closed");
  a_cfg_take: assert property (
    cfg_load && hardware_clear_n |-> ##[1:2] cfg_state == cfg_in && sync_mode == cfg_in.sync_en)
    else $error("config not loaded");
  a_ce_stop: assert property (
    chip_enable_n [*2] |=> !data_valid_flag) else $error("flag after deselect");
  a_suspend_hold: assert property (
    (sync_mode && output_enable_n && address_valid_n && !chip_enable_n && hardware_clear_n) [*3]
    |=> $stable(array_addr) && $stable(data_valid_flag)) else $error("suspend moved");
  // main scenarios reached
  c_cfg: cover property (cfg_load);
  c_first: cover property (sync_mode && $rose(data_valid_flag));
  c_susp: cover property (sync_mode && output_enable_n && !chip_enable_n);
endmodule // fbrp_read_port_sva

bind fbrp_read_port fbrp_read_port_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
  .SLOW_EXTRA(SLOW_EXTRA)) i_sva (.core_clk(core_clk), .rst_n(rst_n),
  .hardware_clear_n(hardware_clear_n), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .address_valid_n(address_valid_n), .address_inputs(address_inputs), .cfg_load(cfg_load),
  .cfg_in(cfg_in), .cmd_write(cmd_write), .cmd_bank_sel(cmd_bank_sel),
  .array_rdata(array_rdata), .array_addr(array_addr), .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe), .data_valid_flag(data_valid_flag),
  .data_valid_flag_oe(data_valid_flag_oe), .bank_read_en(bank_read_en),
  .cfg_state(cfg_state), .sync_mode(sync_mode));

// file: fbrp_host_model.sv
// ==========================================================================
// host controller model
// ==========================================================================
module fbrp_host_model (
  input wire logic core_clk, // core clock
  input wire logic data_valid_flag, // ready from device
  input wire logic [15:0] data_lines_out, // device data
  output logic chip_enable_n, // chip enable
  output logic output_enable_n, // output enable
  output logic write_enable_n, // write enable
  output logic address_valid_n, // address strobe
  output logic burst_clk, // burst clock, still between bursts
  output logic [21:0] address_inputs // word address
);
  timeunit 1ns;
  timeprecision 1ns;
  logic got_flag;
  logic [15:0] got_data;
  // idle bus at time zero
  initial begin
    {chip_enable_n, output_enable_n, write_enable_n, address_valid_n} = 4'hF;
    burst_clk = 1'b0;
    address_inputs = 22'h0;
    got_flag = 1'b0;
    got_data = 16'h0;
  end
  // every host move lands just after a core edge
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // address scrambled once latched, so a stale bus cannot pass for a hold
  task automatic async_rd(input logic [21:0] a);
    chip_enable_n = 1'b0;
    write_enable_n = 1'b1;
    address_inputs = a;
    address_valid_n = 1'b0;
    cyc(1);
    address_valid_n = 1'b1;
    cyc(1);
    address_inputs = ~a;
    cyc(3);
  endtask
  // long half periods let the sampled clock and the data register settle
  task automatic edge_step();
    burst_clk = 1'b1;
    cyc(4);
    got_flag = data_valid_flag;
    if (data_valid_flag) got_data = data_lines_out;
    burst_clk = 1'b0;
    cyc(4);
  endtask
  // bursts stay far below the wrap limit and the span limit
  task automatic start(input logic [21:0] a);
    chip_enable_n = 1'b0;
    write_enable_n = 1'b1;
    output_enable_n = 1'b0;
    address_inputs = a;
    address_valid_n = 1'b0;
    edge_step();
    address_valid_n = 1'b1;
    address_inputs = ~a;
  endtask
  task automatic set_oe(input logic v);
    output_enable_n = v;
  endtask
  task automatic stop();
    chip_enable_n = 1'b1;
    output_enable_n = 1'b1;
  endtask
endmodule // fbrp_host_model

// file: flash_burst_read_port_test.sv
module flash_burst_read_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_n, hardware_clear_n, reduced_wait_part, cfg_load, cmd_write;
  logic chip_enable_n, output_enable_n, write_enable_n, address_valid_n, burst_clk;
  logic [21:0] address_inputs, array_addr;
  logic [15:0] array_rdata, data_lines_out;
  logic data_lines_oe, data_valid_flag, data_valid_flag_oe, sync_mode, slow_clock, edge_fall;
  logic [3:0] cmd_bank_sel, bank_busy, bank_read_en;
  fbrp_pkg::fbrp_cfg_s cfg_in, cfg_state;
  int failures, n_tests;
  logic [15:0] status_val = 16'hC3C3;
  localparam logic [21:0] all_ones = 22'h3FFFFF;
  // array stand-in: content follows the address
  assign array_rdata = array_addr[15:0] ^ 16'h5A5A;
  always #50 core_clk = ~core_clk;
  fbrp_read_port i_dut (.core_clk(core_clk), .rst_n(rst_n), .hardware_clear_n(hardware_clear_n),
    .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .address_valid_n(address_valid_n), .burst_clk(burst_clk),
    .address_inputs(address_inputs), .reduced_wait_part(reduced_wait_part),
    .slow_clock(slow_clock), .cfg_load(cfg_load), .cfg_in(cfg_in), .cmd_write(cmd_write),
    .cmd_bank_sel(cmd_bank_sel), .bank_busy(bank_busy), .status_word(status_val),
    .array_rdata(array_rdata), .array_addr(array_addr), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .data_valid_flag(data_valid_flag),
    .data_valid_flag_oe(data_valid_flag_oe), .bank_read_en(bank_read_en),
    .cfg_state(cfg_state), .sync_mode(sync_mode));
  fbrp_host_model i_host (.core_clk(core_clk), .data_valid_flag(data_valid_flag),
    .data_lines_out(data_lines_out), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .address_valid_n(address_valid_n), .burst_clk(burst_clk), .address_inputs(address_inputs));
  function automatic logic [21:0] mem(input logic [21:0] a);
    return {6'h0, a[15:0] ^ 16'h5A5A};
  endfunction
  task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, 22'(e), 22'(g));
  endtask
  task automatic cfg(input fbrp_pkg::fbrp_mode_e m);
    cfg_in = '{4'h2, m, edge_fall, 1'b0, 1'b1};
    cfg_load = 1'b1;
    i_host.cyc(1);
    cfg_load = 1'b0;
    i_host.cyc(1);
  endtask
  // one burst: latency edges, then words with a two-edge gap at a 64-word crossing
  task automatic run(input logic [21:0] a, input int lat, input int n, input logic [21:0] msk,
    input bit gap);
    logic [21:0] p;
    p = a;
    i_host.start(a);
    repeat (lat - 1) begin
      i_host.edge_step();
      chkb("wait flag", 1'b0, i_host.got_flag);
    end
    repeat (n) begin
      if (gap && p[5:0] == 6'h00 && p != a) begin
        repeat (2) begin
          i_host.edge_step();
          chkb("gap flag", 1'b0, i_host.got_flag);
        end
      end
      i_host.edge_step();
      chkb("word flag", 1'b1, i_host.got_flag);
      chk("word", mem(p), 22'(i_host.got_data));
      p = (p & ~msk) | ((p + 22'h1) & msk);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog sized well above the expected run of about 1200 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    $display("[ERR] watchdog expected end seen hang");
    tally_and_finish();
  end
  // main sequence
  initial begin
    {core_clk, rst_n, reduced_wait_part, cfg_load, cmd_write, slow_clock, edge_fall} = 7'h00;
    hardware_clear_n = 1'b1;
    {cmd_bank_sel, bank_busy} = 8'h00;
    cfg_in = '0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    i_host.cyc(2);
    chk("banks", 22'hF, 22'(bank_read_en));
    chk("cfg", 22'({4'h5, fbrp_pkg::FBRP_CONT, 3'h0}), 22'(cfg_state));
    chkb("sync", 1'b0, sync_mode);
    i_host.async_rd(22'h001234);
    chk("async data", mem(22'h001234), 22'(data_lines_out));
    cmd_bank_sel = 4'h2;
    cmd_write = 1'b1;
    i_host.cyc(1);
    cmd_write = 1'b0;
    i_host.cyc(1);
    chk("banks", 22'hD, 22'(bank_read_en));
    i_host.async_rd(22'h080010);
    chk("closed bank", 22'(status_val), 22'(data_lines_out));
    $display("test async finished");
    cfg(fbrp_pkg::FBRP_CONT);
    chkb("sync", 1'b1, sync_mode);
    chk("cfg", 22'(cfg_in), 22'(cfg_state));
    run(22'h00003C, 2, 6, all_ones, 1'b1);
    run(22'h00007E, 2, 4, all_ones, 1'b0);
    run(22'h0000BB, 3, 6, all_ones, 1'b1);
    run(22'h000100, 2, 1, all_ones, 1'b0);
    i_host.set_oe(1'b1);
    repeat (2) i_host.edge_step();
    chk("held addr", 22'h000100, array_addr);
    chkb("flag oe", 1'b1, data_valid_flag_oe);
    chkb("data oe", 1'b0, data_lines_oe);
    i_host.set_oe(1'b0);
    i_host.edge_step();
    chk("resume", mem(22'h000101), 22'(i_host.got_data));
    i_host.stop();
    i_host.cyc(2);
    chkb("flag off", 1'b0, data_valid_flag);
    chkb("flag oe", 1'b0, data_valid_flag_oe);
    $display("test continuous finished");
    for (int m = 1; m < 4; m++) begin
      cfg(fbrp_pkg::fbrp_mode_e'(m));
      run(22'h00003D, 3, (8 << (m - 1)) + 2, 22'((8 << (m - 1)) - 1), 1'b1);
    end
    cfg(fbrp_pkg::FBRP_CONT);
    bank_busy = 4'h2;
    run(22'h07FFFC, 2, 4, all_ones, 1'b0);
    repeat (4) i_host.edge_step();
    chk("status", 22'(status_val), 22'(data_lines_out));
    chkb("status flag", 1'b1, data_valid_flag);
    repeat (2) i_host.edge_step();
    chk("status", 22'(status_val), 22'(data_lines_out));
    i_host.stop();
    hardware_clear_n = 1'b0;
    i_host.cyc(1);
    hardware_clear_n = 1'b1;
    i_host.cyc(1);
    chk("banks", 22'hF, 22'(bank_read_en));
    chkb("sync", 1'b0, sync_mode);
    $display("test wrap and status finished");
    rst_n = 1'b0;
    reduced_wait_part = 1'b1;
    bank_busy = 4'h0;
    i_host.cyc(2);
    rst_n = 1'b1;
    i_host.cyc(2);
    cfg(fbrp_pkg::FBRP_CONT);
    run(22'h00003E, 4, 4, all_ones, 1'b0);
    run(22'h000041, 2, 2, all_ones, 1'b0);
    run(22'h07FFFC, 2, 6, all_ones, 1'b1);
    slow_clock = 1'b1;
    edge_fall = 1'b1;
    cfg(fbrp_pkg::FBRP_CONT);
    run(22'h000010, 5, 2, all_ones, 1'b0);
    $display("test reduced finished");
    tally_and_finish();
  end
endmodule // flash_burst_read_port_test
